// ==== inc/vme_image_pkg.sv ====
// Shared offsets, field layouts and carriers of the slave image decoder
package vme_image_pkg;
    // Register offsets (byte addresses, low 12 bits)
    localparam logic [11:0] OFF_CMD = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_DEST = 12'h00c;
    localparam logic [11:0] OFF_I5_TO = 12'hfb0;
    localparam logic [11:0] OFF_I6_CTL = 12'hfb8;
    localparam logic [11:0] OFF_I6_BS = 12'hfbc;
    localparam logic [11:0] OFF_I6_BD = 12'hfc0;
    localparam logic [11:0] OFF_I6_TO = 12'hfc4;
    localparam logic [11:0] OFF_I7_CTL = 12'hfcc;
    localparam logic [11:0] OFF_I7_BS = 12'hfd0;
    localparam logic [11:0] OFF_I7_BD = 12'hfd4;
    localparam logic [11:0] OFF_I7_TO = 12'hfd8;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 11;

    // Reset values and writable-bit masks
    localparam logic [31:0] CTL_RESET = 32'h00f00000;
    localparam logic [31:0] CTL_WMASK = 32'he0f700c3;
    localparam logic [31:0] WIN_MASK = 32'hffff0000;
    localparam logic [31:0] CMD_WMASK = 32'h00000004;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam int BME_BIT = 2;

    // Backplane space codes
    localparam logic [2:0] VAS_A24 = 3'h1;
    localparam logic [2:0] VAS_A32 = 3'h2;
    localparam logic [2:0] VAS_USER1 = 3'h6;
    localparam logic [2:0] VAS_USER2 = 3'h7;
    // Modifier groups seen in modifier bits 5..3
    localparam logic [2:0] AM_GRP_A24 = 3'h7;
    localparam logic [2:0] AM_GRP_A32 = 3'h1;
    localparam logic [2:0] AM_GRP_USER1 = 3'h2;
    localparam logic [2:0] AM_GRP_USER2 = 3'h3;
    localparam logic [1:0] AM_PROGRAM = 2'h2;
    localparam logic [5:0] AM_A24_SUP_DATA = 6'h3d;

    // Local space codes
    localparam logic [1:0] LAS_MEM = 2'h0;
    localparam logic [1:0] LAS_IO = 2'h1;
    localparam logic [1:0] LAS_CFG = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Image control word
    typedef struct packed {
        logic en;
        logic posted_write_enable;
        logic prefetch_read_enable;
        logic [4:0] rsv0;
        logic [1:0] program_data_select;
        logic [1:0] privilege_select;
        logic rsv1;
        logic [2:0] backplane_space_select;
        logic [7:0] rsv2;
        logic wide_local_transfer_enable;
        logic local_lock_on_rmw;
        logic [3:0] rsv3;
        logic [1:0] local_space_select;
    } ctl_t;

    // Incoming backplane cycle
    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am;
        logic write;
        logic rmw;
    } cycle_t;

    // Forwarded local request
    typedef struct packed {
        logic claim;
        logic image7;
        logic [31:0] addr;
        logic [1:0] space;
        logic posted;
        logic prefetch;
        logic wide;
        logic lock;
    } fwd_t;
endpackage

// ==== core/image_match.sv ====
// Window, modifier match and address translation of one slave image
`timescale 1ns/10ps
module image_match (
    input wire vme_image_pkg::ctl_t ctl,
    input wire logic [31:0] window_base,
    input wire logic [31:0] window_bound,
    input wire logic [31:0] translation_offset,
    input wire vme_image_pkg::cycle_t cyc,
    input wire logic bus_master_enable,
    output logic hit,
    output logic [31:0] dest
);
    // Space has to agree; program/data and privilege also have to, except in User1 and User2 spaces
    function automatic logic am_ok(vme_image_pkg::ctl_t c, logic [5:0] am);
        logic sp;
        logic usr;
        logic pd;
        logic pr;
        usr = 1'b0;
        case (c.backplane_space_select)
            vme_image_pkg::VAS_A24: sp = (am[5:3] == vme_image_pkg::AM_GRP_A24);
            vme_image_pkg::VAS_A32: sp = (am[5:3] == vme_image_pkg::AM_GRP_A32);
            vme_image_pkg::VAS_USER1: begin
                sp = (am[5:3] == vme_image_pkg::AM_GRP_USER1);
                usr = 1'b1;
            end
            vme_image_pkg::VAS_USER2: begin
                sp = (am[5:3] == vme_image_pkg::AM_GRP_USER2);
                usr = 1'b1;
            end
            default: sp = 1'b0; // Reserved space codes never match
        endcase
        // Code 00 in either field leaves both bits clear, so only User1 and User2 cycles match
        pd = (am[1:0] == vme_image_pkg::AM_PROGRAM) ? c.program_data_select[1]
                                                    : c.program_data_select[0];
        pr = am[2] ? c.privilege_select[1] : c.privilege_select[0];
        return sp && (usr || (pd && pr));
    endfunction

    logic [15:0] hi;
    logic in_win;

    // Only bits 31..16 take part; 64 KB granularity
    assign hi = cyc.addr[31:16];
    assign in_win = (hi >= window_base[31:16]) &&
                    ((window_bound[31:16] == 16'h0000) ||
                     (hi < window_bound[31:16]));

    // Claim needs enable, bus mastering, window and modifier together
    assign hit = ctl.en && bus_master_enable && in_win &&
                 am_ok(ctl, cyc.am);

    // Two's complement offset gives downward moves for free
    assign dest = {hi + translation_offset[31:16], cyc.addr[15:0]};
endmodule

// ==== core/vme_slave_image_decode.sv ====
// Inbound slave images six and seven: registers, decode and forwarding
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
// What this block does
// - Decode only addresses at or above base and strictly below bound.
// - A zero bound leaves the window open above the base.
// - Destination address is source address plus translation offset.
// - An image answers only while its enable bit is set; resets off.
// - No image answers unless the bus master enable bit is set.
// - Space field 001 A24, 010 A32, 110 User1, 111 User2; resets zero.
// - Program/data field 01 data, 10 program, 11 both; resets 11.
// - Privilege field 01 user, 10 supervisor, 11 both; resets 11.
// - Local space field 00 memory, 01 I/O, 10 config; resets memory.
// - Only memory destinations go through the posted write buffer.
// - Posting and prefetch bits are ignored outside memory space.
// - Posted write enable posts memory writes; resets off.
// - Prefetch enable prefetches memory reads; resets off.
// - Wide local transfers only when the wide enable bit is set.
// - Lock local bus over read-modify-write when lock bit set.
module vme_slave_image_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bp_cycle_n,
    input wire vme_image_pkg::cycle_t bp_cycle,
    output vme_image_pkg::fwd_t loc_req
);
    // Byte-lane merge, reserved bits forced to zero
    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] data,
                                          logic [3:0] strb, logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res & mask;
    endfunction

    // Which offsets exist; everything else answers DECERR
    function automatic logic mapped(logic [11:0] a);
        case (a)
            vme_image_pkg::OFF_CMD, vme_image_pkg::OFF_STATUS,
            vme_image_pkg::OFF_DEST, vme_image_pkg::OFF_I5_TO,
            vme_image_pkg::OFF_I6_CTL, vme_image_pkg::OFF_I6_BS,
            vme_image_pkg::OFF_I6_BD, vme_image_pkg::OFF_I6_TO,
            vme_image_pkg::OFF_I7_CTL, vme_image_pkg::OFF_I7_BS,
            vme_image_pkg::OFF_I7_BD, vme_image_pkg::OFF_I7_TO: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    logic awready_r;
    logic wready_r;
    logic aw_full_r;
    logic w_full_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_word;
    logic wr_do;
    logic [31:0] cmd_r;
    logic [31:0] i5_to_r;
    vme_image_pkg::ctl_t i6_ctl_r;
    vme_image_pkg::ctl_t i7_ctl_r;
    logic [31:0] i6_bs_r;
    logic [31:0] i6_bd_r;
    logic [31:0] i6_to_r;
    logic [31:0] i7_bs_r;
    logic [31:0] i7_bd_r;
    logic [31:0] i7_to_r;
    logic strb_s1_r;
    logic strb_s2_r;
    logic strb_s3_r;
    vme_image_pkg::cycle_t cyc_s1_r;
    vme_image_pkg::cycle_t cyc_s2_r;
    logic start;
    logic active;
    logic hit6;
    logic hit7;
    logic [31:0] dest6;
    logic [31:0] dest7;
    logic bme;
    vme_image_pkg::ctl_t sc;
    vme_image_pkg::fwd_t req_nxt;
    vme_image_pkg::fwd_t loc_req_r;

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign loc_req = loc_req_r;

    // Write address and data are taken in either order, then committed
    assign wr_do = aw_full_r && w_full_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= vme_image_pkg::RESP_OKAY;
            aw_addr_r <= 12'h000;
            w_data_r <= vme_image_pkg::ZERO_WORD;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                aw_addr_r <= s_axi_awaddr[vme_image_pkg::ADDR_MSB:vme_image_pkg::ADDR_LSB];
            end
            if (s_axi_wvalid && wready_r) begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= mapped(aw_addr_r) ? vme_image_pkg::RESP_OKAY
                                             : vme_image_pkg::RESP_DECERR;
            end
            // Channels reopen only after the response is taken
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Register file; reset values follow the documented power-up state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= vme_image_pkg::ZERO_WORD;
            i5_to_r <= vme_image_pkg::ZERO_WORD;
            i6_ctl_r <= vme_image_pkg::CTL_RESET;
            i7_ctl_r <= vme_image_pkg::CTL_RESET;
            i6_bs_r <= vme_image_pkg::ZERO_WORD;
            i6_bd_r <= vme_image_pkg::ZERO_WORD;
            i6_to_r <= vme_image_pkg::ZERO_WORD;
            i7_bs_r <= vme_image_pkg::ZERO_WORD;
            i7_bd_r <= vme_image_pkg::ZERO_WORD;
            i7_to_r <= vme_image_pkg::ZERO_WORD;
        end else if (wr_do) begin
            case (aw_addr_r)
                vme_image_pkg::OFF_CMD:
                    cmd_r <= merge(cmd_r, w_data_r, w_strb_r, vme_image_pkg::CMD_WMASK);
                vme_image_pkg::OFF_I5_TO:
                    i5_to_r <= merge(i5_to_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I6_CTL:
                    i6_ctl_r <= merge(i6_ctl_r, w_data_r, w_strb_r, vme_image_pkg::CTL_WMASK);
                vme_image_pkg::OFF_I6_BS:
                    i6_bs_r <= merge(i6_bs_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I6_BD:
                    i6_bd_r <= merge(i6_bd_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I6_TO:
                    i6_to_r <= merge(i6_to_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I7_CTL:
                    i7_ctl_r <= merge(i7_ctl_r, w_data_r, w_strb_r, vme_image_pkg::CTL_WMASK);
                vme_image_pkg::OFF_I7_BS:
                    i7_bs_r <= merge(i7_bs_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I7_BD:
                    i7_bd_r <= merge(i7_bd_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                vme_image_pkg::OFF_I7_TO:
                    i7_to_r <= merge(i7_to_r, w_data_r, w_strb_r, vme_image_pkg::WIN_MASK);
                default: ; // Status, destination and holes ignore writes
            endcase
        end
    end

    // Read data selection; status shows the request being forwarded
    always_comb begin
        case (s_axi_araddr[vme_image_pkg::ADDR_MSB:vme_image_pkg::ADDR_LSB])
            vme_image_pkg::OFF_CMD: rd_word = cmd_r;
            vme_image_pkg::OFF_STATUS: rd_word = {24'h000000, loc_req_r.claim,
                loc_req_r.image7, loc_req_r.space, loc_req_r.posted,
                loc_req_r.prefetch, loc_req_r.wide, loc_req_r.lock};
            vme_image_pkg::OFF_DEST: rd_word = loc_req_r.addr;
            vme_image_pkg::OFF_I5_TO: rd_word = i5_to_r;
            vme_image_pkg::OFF_I6_CTL: rd_word = i6_ctl_r;
            vme_image_pkg::OFF_I6_BS: rd_word = i6_bs_r;
            vme_image_pkg::OFF_I6_BD: rd_word = i6_bd_r;
            vme_image_pkg::OFF_I6_TO: rd_word = i6_to_r;
            vme_image_pkg::OFF_I7_CTL: rd_word = i7_ctl_r;
            vme_image_pkg::OFF_I7_BS: rd_word = i7_bs_r;
            vme_image_pkg::OFF_I7_BD: rd_word = i7_bd_r;
            vme_image_pkg::OFF_I7_TO: rd_word = i7_to_r;
            default: rd_word = vme_image_pkg::ZERO_WORD;
        endcase
    end

    // Read channel answers on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= vme_image_pkg::RESP_OKAY;
            rdata_r <= vme_image_pkg::ZERO_WORD;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= mapped(s_axi_araddr[vme_image_pkg::ADDR_MSB:vme_image_pkg::ADDR_LSB])
                       ? vme_image_pkg::RESP_OKAY : vme_image_pkg::RESP_DECERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Backplane pins are asynchronous; address is stable before the strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strb_s1_r <= 1'b1;
            strb_s2_r <= 1'b1;
            strb_s3_r <= 1'b1;
            cyc_s1_r <= '0;
            cyc_s2_r <= '0;
        end else begin
            strb_s1_r <= bp_cycle_n;
            strb_s2_r <= strb_s1_r;
            strb_s3_r <= strb_s2_r;
            cyc_s1_r <= bp_cycle;
            cyc_s2_r <= cyc_s1_r;
        end
    end

    assign active = !strb_s2_r;
    assign start = !strb_s2_r && strb_s3_r;
    assign bme = cmd_r[vme_image_pkg::BME_BIT];

    image_match u_img6 (
        .ctl(i6_ctl_r),
        .window_base(i6_bs_r),
        .window_bound(i6_bd_r),
        .translation_offset(i6_to_r),
        .cyc(cyc_s2_r),
        .bus_master_enable(bme),
        .hit(hit6),
        .dest(dest6)
    );

    image_match u_img7 (
        .ctl(i7_ctl_r),
        .window_base(i7_bs_r),
        .window_bound(i7_bd_r),
        .translation_offset(i7_to_r),
        .cyc(cyc_s2_r),
        .bus_master_enable(bme),
        .hit(hit7),
        .dest(dest7)
    );

    // Overlapping windows: image six has priority
    assign sc = hit6 ? i6_ctl_r : i7_ctl_r;

    // Local request built from the claiming image's controls
    always_comb begin
        req_nxt = '0;
        if (hit6 || hit7) begin
            req_nxt.claim = 1'b1;
            req_nxt.image7 = !hit6;
            req_nxt.addr = hit6 ? dest6 : dest7;
            req_nxt.space = sc.local_space_select;
            // Posting and prefetch only mean something for memory
            req_nxt.posted = (sc.local_space_select == vme_image_pkg::LAS_MEM) &&
                             cyc_s2_r.write && sc.posted_write_enable;
            req_nxt.prefetch = (sc.local_space_select == vme_image_pkg::LAS_MEM) &&
                               !cyc_s2_r.write && sc.prefetch_read_enable;
            req_nxt.wide = sc.wide_local_transfer_enable;
            req_nxt.lock = cyc_s2_r.rmw && sc.local_lock_on_rmw;
        end
    end

    // Decision is latched at cycle start and held until the strobe rises again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loc_req_r <= '0;
        end else if (start) begin
            loc_req_r <= req_nxt;
        end else if (!active) begin
            loc_req_r <= '0;
        end
    end

    // Checks on the decision and on the write response
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic in_win6;
    assign in_win6 = (cyc_s2_r.addr[31:16] >= i6_bs_r[31:16]) &&
                     ((i6_bd_r[31:16] == 16'h0000) ||
                      (cyc_s2_r.addr[31:16] < i6_bd_r[31:16]));

    a_window_six: assert property (
        $rose(loc_req_r.claim) && !loc_req_r.image7 |-> $past(in_win6))
        else $error("image six claimed outside its window");

    a_open_bound: assert property (
        start && i6_ctl_r.en && bme && i6_bd_r[31:16] == 16'h0000 &&
        cyc_s2_r.addr[31:16] >= i6_bs_r[31:16] &&
        i6_ctl_r.backplane_space_select == vme_image_pkg::VAS_A24 &&
        cyc_s2_r.am == vme_image_pkg::AM_A24_SUP_DATA &&
        i6_ctl_r.program_data_select[0] && i6_ctl_r.privilege_select[1]
        |=> loc_req_r.claim && !loc_req_r.image7)
        else $error("open-ended window did not claim");

    a_translate_addr: assert property (
        $rose(loc_req_r.claim) && !loc_req_r.image7 |->
        loc_req_r.addr == {$past(cyc_s2_r.addr[31:16]) + i6_to_r[31:16],
                           $past(cyc_s2_r.addr[15:0])})
        else $error("translated address wrong");

    a_enable_gate: assert property (
        $rose(loc_req_r.claim) |-> (loc_req_r.image7 ? $past(i7_ctl_r.en) : $past(i6_ctl_r.en)))
        else $error("disabled image claimed a cycle");

    a_master_gate: assert property (
        start && !bme |=> !loc_req_r.claim [*2])
        else $error("claim without bus master enable");

    a_mem_only: assert property (
        loc_req_r.posted || loc_req_r.prefetch |->
        loc_req_r.space == vme_image_pkg::LAS_MEM && loc_req_r.claim)
        else $error("posting or prefetch outside memory space");

    a_posted_write: assert property (
        $rose(loc_req_r.claim) && loc_req_r.space == vme_image_pkg::LAS_MEM &&
        $past(cyc_s2_r.write) |-> loc_req_r.posted ==
        (loc_req_r.image7 ? i7_ctl_r.posted_write_enable : i6_ctl_r.posted_write_enable))
        else $error("memory write posting mismatch");

    a_lock_rmw: assert property (
        $rose(loc_req_r.lock) |-> $past(cyc_s2_r.rmw) && loc_req_r.claim)
        else $error("local lock without read-modify-write");

    a_cycle_end: assert property (
        $rose(strb_s2_r) |=> !loc_req_r.claim)
        else $error("claim outlived the backplane cycle");

    a_bresp_hold: assert property (
        bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before taken");

    c_claim_six: cover property ($rose(loc_req_r.claim) && !loc_req_r.image7);
    c_claim_seven: cover property ($rose(loc_req_r.claim) && loc_req_r.image7);
    c_posted: cover property ($rose(loc_req_r.posted));
    c_write_done: cover property (bvalid_r && s_axi_bready);
endmodule

// ==== test/bp_master_model.sv ====
// Backplane master model that drives cycles into the image decoder
`timescale 1ns/10ps
module bp_master_model (
    input wire logic aclk,
    output logic bp_cycle_n,
    output vme_image_pkg::cycle_t bp_cycle
);
    initial begin
        bp_cycle_n = 1'b1;
        bp_cycle = '0;
    end
    // Lines settle two or more clocks before the strobe falls, as the sync chain needs
    task automatic start(input vme_image_pkg::cycle_t c, input int slow);
        bp_cycle <= c;
        repeat (2 + slow) @(posedge aclk);
        bp_cycle_n <= 1'b0;
    endtask
    // Released lines are inverted so a stale value never passes for a live one
    task automatic stop();
        bp_cycle_n <= 1'b1;
        @(posedge aclk);
        bp_cycle <= ~bp_cycle;
    endtask
endmodule

// ==== test/tb_vme_slave_image_decode.sv ====
// Self-checking bench for the slave image decoder
`timescale 1ns/10ps
module tb_vme_slave_image_decode;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic ready_hi = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, bp_cycle_n, bme;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, base6, bound6, to6;
    vme_image_pkg::cycle_t bp_cycle;
    vme_image_pkg::fwd_t loc_req;
    vme_image_pkg::ctl_t ctl6;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    always #50 aclk = ~aclk;

    // Read data taken at once; write responses one edge late
    vme_slave_image_decode dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(ready_hi),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(ready_hi), .bp_cycle_n(bp_cycle_n), .bp_cycle(bp_cycle), .loc_req(loc_req));
    bp_master_model pm (.aclk(aclk), .bp_cycle_n(bp_cycle_n), .bp_cycle(bp_cycle));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Bus tasks start after an edge; each valid drops once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er = vme_image_pkg::RESP_OKAY);
        awaddr <= {20'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ready_hi <= bvalid;
        end while (bvalid !== 1'b1 || !ready_hi);
        chk(bresp, er);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er = vme_image_pkg::RESP_OKAY);
        araddr <= {20'h0, a};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(rresp, er);
    endtask

    // Valid modifier group for a space code; reserved codes get no group
    function automatic logic [3:0] grp(input logic [2:0] v);
        case (v)
            vme_image_pkg::VAS_A24: return {1'b1, vme_image_pkg::AM_GRP_A24};
            vme_image_pkg::VAS_A32: return {1'b1, vme_image_pkg::AM_GRP_A32};
            vme_image_pkg::VAS_USER1: return {1'b1, vme_image_pkg::AM_GRP_USER1};
            vme_image_pkg::VAS_USER2: return {1'b1, vme_image_pkg::AM_GRP_USER2};
            default: return 4'h0;
        endcase
    endfunction

    function automatic vme_image_pkg::fwd_t predict(input vme_image_pkg::cycle_t c);
        vme_image_pkg::fwd_t f;
        logic hit, mem;
        f = '0;
        hit = grp(ctl6.backplane_space_select) == {1'b1, c.am[5:3]};
        if (!ctl6.backplane_space_select[2]) begin
            hit &= c.am[1:0] == vme_image_pkg::AM_PROGRAM ? ctl6.program_data_select[1]
                : ctl6.program_data_select[0];
            hit &= c.am[2] ? ctl6.privilege_select[1] : ctl6.privilege_select[0];
        end
        hit &= ctl6.en && bme && c.addr[31:16] >= base6[31:16]
            && (bound6[31:16] == 16'h0 || c.addr[31:16] < bound6[31:16]);
        mem = ctl6.local_space_select == vme_image_pkg::LAS_MEM;
        if (hit) begin
            f.claim = 1'b1;
            f.addr = {c.addr[31:16] + to6[31:16], c.addr[15:0]};
            f.space = ctl6.local_space_select;
            f.posted = mem & c.write & ctl6.posted_write_enable;
            f.prefetch = mem & !c.write & ctl6.prefetch_read_enable;
            f.wide = ctl6.wide_local_transfer_enable;
            f.lock = c.rmw & ctl6.local_lock_on_rmw;
        end
        return f;
    endfunction

    task automatic cfg();
        wr(vme_image_pkg::OFF_I6_CTL, ctl6);
        wr(vme_image_pkg::OFF_I6_BS, base6);
        wr(vme_image_pkg::OFF_I6_BD, bound6);
        wr(vme_image_pkg::OFF_I6_TO, to6);
        wr(vme_image_pkg::OFF_CMD, {29'h0, bme, 2'h0});
        rd(vme_image_pkg::OFF_I6_CTL, ctl6 & vme_image_pkg::CTL_WMASK);
        rd(vme_image_pkg::OFF_I6_TO, to6 & vme_image_pkg::WIN_MASK);
    endtask

    task automatic bp_check(input logic [31:0] a, input logic [5:0] am, input logic w, r);
        vme_image_pkg::cycle_t c;
        c = {a, am, w, r};
        pm.start(c, $urandom_range(0, 2));
        repeat (4) @(posedge aclk);
        chk(loc_req, predict(c));
        pm.stop();
        repeat (4) @(posedge aclk);
        chk(loc_req, '0);
    endtask

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        logic [3:0] g;
        void'($urandom(2680));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(vme_image_pkg::OFF_I6_CTL, vme_image_pkg::CTL_RESET);
        rd(vme_image_pkg::OFF_I7_CTL, vme_image_pkg::CTL_RESET);
        rd(vme_image_pkg::OFF_I7_BS, '0);
        rd(vme_image_pkg::OFF_I5_TO, '0);
        rd(12'h010, '0, vme_image_pkg::RESP_DECERR);
        wr(12'h010, 32'hffffffff, vme_image_pkg::RESP_DECERR);
        $display("test reset_values done");
        ctl6 = vme_image_pkg::CTL_RESET;
        ctl6.en = 1'b1;
        ctl6.backplane_space_select = vme_image_pkg::VAS_A32;
        base6 = 32'h1234abcd;
        bound6 = 32'h12400000;
        to6 = 32'hfff00000;
        bme = 1'b0;
        cfg();
        bp_check(32'h12345678, 6'h09, 1'b1, 1'b0);
        bme = 1'b1;
        cfg();
        bp_check(32'h1233ffff, 6'h0d, 1'b0, 1'b1);
        bp_check(32'h12340000, 6'h0d, 1'b0, 1'b1);
        bp_check(32'h123fffff, 6'h0d, 1'b1, 1'b0);
        bp_check(32'h12400000, 6'h0d, 1'b0, 1'b0);
        bound6 = '0;
        ctl6.backplane_space_select = vme_image_pkg::VAS_A24;
        cfg();
        bp_check(32'hffff0010, 6'h3d, 1'b1, 1'b0);
        ctl6.en = 1'b0;
        cfg();
        bp_check(32'h12350000, 6'h3d, 1'b0, 1'b0);
        $display("test window_edges done");
        for (int i = 0; i < 40; i++) begin
            ctl6 = $urandom & vme_image_pkg::CTL_WMASK;
            ctl6.en = $urandom_range(0, 7) != 0;
            ctl6.local_space_select = 2'($urandom_range(0, 2));
            bme = $urandom_range(0, 5) != 0;
            base6 = $urandom;
            bound6 = $urandom_range(0, 3) == 0 ? '0 : base6 + $urandom_range(0, 32'h00400000);
            to6 = $urandom;
            cfg();
            g = grp(ctl6.backplane_space_select);
            repeat (3) begin
                bp_check(base6 + $urandom_range(0, 32'h00500000) - 32'h00010000,
                    $urandom_range(0, 3) == 0 ? 6'($urandom) : {g[2:0], 3'($urandom)},
                    1'($urandom), 1'($urandom));
            end
        end
        $display("test random done");
        complete_run();
    end
endmodule
